// >>> npic_params.svh
// constants of the nested priority interrupt controller
// assumes a 32-bit avalon word per register, word addressing on the slave
`ifndef NPIC_PARAMS_SVH
`define NPIC_PARAMS_SVH

// register word indices
`define NPIC_REG_PRIO0 4'h0
`define NPIC_REG_PRIO3 4'h3
`define NPIC_REG_VEN 4'h4
`define NPIC_REG_EXT 4'h5
`define NPIC_REG_CTRL 4'h6
`define NPIC_REG_STAT 4'h7

// reset values
`define NPIC_PRIO_RST 8'hff
`define NPIC_PRIO3_RO 8'hf0
`define NPIC_CTRL_RST 8'h01
`define NPIC_VEN_RST 16'h0000
`define NPIC_EXT_RST 8'h00

// priority pair codes, {high bit, low bit}
`define NPIC_LVL0 2'b10
`define NPIC_LVL1 2'b01
`define NPIC_LVL2 2'b00
`define NPIC_LVL3 2'b11

// external group sensitivity codes
`define NPIC_SENS_FALL_LOW 2'b00
`define NPIC_SENS_RISE 2'b01
`define NPIC_SENS_FALL 2'b10
`define NPIC_SENS_BOTH 2'b11

// vector addresses and indices for the non-maskable entries
`define NPIC_VEC_RESET 16'hfffe
`define NPIC_VEC_TRAP 16'hfffc
`define NPIC_VEC_TOP 16'hfffa
`define NPIC_IDX_RESET 4'hf
`define NPIC_IDX_TRAP 4'he
`define NPIC_IDX_TOP 4'h0

`endif

// >>> npic_pkg.sv
// types shared by the interrupt controller files
// assumes nothing beyond the params header
package npic_pkg;
	typedef enum logic [2:0] {
		NPIC_S_BOOT = 3'b000,
		NPIC_S_IDLE = 3'b001,
		NPIC_S_PUSH = 3'b010,
		NPIC_S_LOAD = 3'b011
	} npic_state_t;
	typedef logic [1:0] npic_prio_t;
endpackage

// >>> npic_prio_mem.sv
// per_vector_priority_regs storage: four bytes, one pair per vector
// assumes writes come from the bus slave on the same clock
`timescale 1ns/1ns
`include "npic_params.svh"
module npic_prio_mem (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic we,
	input wire logic [1:0] wr_idx,
	input wire logic [7:0] wr_data,
	input wire logic [1:0] rd_idx,
	output logic [7:0] rd_data_ff,
	output logic [31:0] prio_flat
);
	import npic_pkg::*;
	logic [7:0] mem_ff [0:3];

	// a level-0 code in a pair keeps the old pair, others take the new one
	function automatic logic [7:0] merge(input logic [7:0] old_v, input logic [7:0] new_v);
		logic [7:0] r;
		r = new_v;
		for (int p = 0; p < 4; p++) begin
			if (new_v[2*p+:2] == `NPIC_LVL0) begin
				r[2*p+:2] = old_v[2*p+:2];
			end
		end
		return r;
	endfunction

	// top nibble of the last byte is fixed high
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < 4; i++) begin
				mem_ff[i] <= `NPIC_PRIO_RST;
			end
		end else if (we) begin
			if (wr_idx == 2'd3) begin
				mem_ff[3] <= merge(mem_ff[3], wr_data) | `NPIC_PRIO3_RO;
			end else begin
				mem_ff[wr_idx] <= merge(mem_ff[wr_idx], wr_data);
			end
		end
	end

	// registered read port for the bus
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_data_ff <= 8'h00;
		end else begin
			rd_data_ff <= mem_ff[rd_idx];
		end
	end

	assign prio_flat = {mem_ff[3], mem_ff[2], mem_ff[1], mem_ff[0]};
endmodule // npic_prio_mem

// >>> npic_ctrl.sv
// nested priority interrupt controller, avalon-mm register slave
// assumes core handshakes come from logic on core_clk; pins are asynchronous
`timescale 1ns/1ns
`include "npic_params.svh"
module npic_ctrl #(
	parameter int NV = 14,
	parameter int EXT_W = 4,
	parameter int EXT_VEC = 4,
	parameter logic [13:0] HALT_CAP = 14'h00df,
	parameter bit TLI_RISING = 1'b0
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic instr_done,
	input wire logic trap_exec,
	input wire logic cc_load,
	input wire npic_pkg::npic_prio_t cc_load_val,
	input wire logic ctx_saved,
	input wire logic halt_mode,
	input wire logic wait_mode,
	input wire logic [13:0] periph_flag,
	input wire logic [13:0] periph_en,
	input wire logic [13:0] periph_clr,
	input wire logic [3:0] ext_pin,
	input wire logic top_level_hw_interrupt,
	output npic_pkg::npic_prio_t cc_prio,
	output logic ctx_push,
	output logic svc_strobe,
	output logic [3:0] svc_index,
	output logic [15:0] vec_addr,
	output logic wake
);
	import npic_pkg::*;

	npic_state_t state_ff;
	logic [1:0] acc_cnt_ff;
	logic [31:0] prio_flat;
	logic [7:0] mem_rd;
	logic mem_we;
	logic [15:0] ven_ff;
	logic [7:0] ext_cfg_ff;
	logic [7:0] ctrl_ff;
	logic [3:0] ext_s1_ff, ext_s2_ff;
	logic tli_s1_ff, tli_s2_ff, tli_d_ff;
	logic comb_d_ff;
	logic ext_lat_ff, tli_lat_ff, trap_lat_ff, halt_exit_ff;
	logic [13:0] per_lat_ff, per_d_ff;
	logic sel_nm_ff;
	logic [3:0] sel_idx_ff;
	logic [3:0] last_idx_ff;
	npic_prio_t sel_prio_ff;
	logic comb_lvl, ext_edge, ext_req, tli_edge, nm_pend;
	logic [13:0] pend, per_req;
	logic best_ok;
	logic [3:0] best_idx;
	logic [1:0] best_lvl;
	logic enter;

	// numeric level of a pair code
	function automatic logic [1:0] lvl(input npic_prio_t c);
		case (c)
			`NPIC_LVL0: lvl = 2'd0;
			`NPIC_LVL1: lvl = 2'd1;
			`NPIC_LVL2: lvl = 2'd2;
			default: lvl = 2'd3;
		endcase
	endfunction

	// vectors step down by two bytes from the top-level slot
	function automatic logic [15:0] vaddr(input logic [3:0] idx);
		vaddr = `NPIC_VEC_TOP - {11'h000, idx, 1'b0};
	endfunction

	npic_prio_mem u_mem (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.we(mem_we),
		.wr_idx(avs_address[1:0]),
		.wr_data(avs_writedata[7:0]),
		.rd_idx(avs_address[1:0]),
		.rd_data_ff(mem_rd),
		.prio_flat(prio_flat)
	);

	// bus: request is held two cycles, then one cycle with waitrequest low
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			acc_cnt_ff <= 2'd0;
			avs_waitrequest <= 1'b1;
		end else if (!avs_waitrequest) begin
			acc_cnt_ff <= 2'd0;
			avs_waitrequest <= 1'b1;
		end else if (avs_read || avs_write) begin
			acc_cnt_ff <= acc_cnt_ff + 2'd1;
			avs_waitrequest <= (acc_cnt_ff != 2'd1);
		end
	end

	// writes take effect only on the accepting edge
	assign mem_we = avs_write && !avs_waitrequest && (avs_address <= `NPIC_REG_PRIO3);

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ven_ff <= `NPIC_VEN_RST;
			ext_cfg_ff <= `NPIC_EXT_RST;
			ctrl_ff <= `NPIC_CTRL_RST;
		end else if (avs_write && !avs_waitrequest) begin
			case (avs_address)
				`NPIC_REG_VEN: ven_ff <= avs_writedata[15:0];
				`NPIC_REG_EXT: ext_cfg_ff <= avs_writedata[7:0];
				`NPIC_REG_CTRL: ctrl_ff <= avs_writedata[7:0];
				default: ;
			endcase
		end
	end

	// read data are loaded on the same edge that waitrequest drops
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			avs_readdata <= 32'h0000_0000;
		end else if (avs_read && avs_waitrequest && acc_cnt_ff == 2'd1) begin
			case (avs_address)
				4'h0, 4'h1, 4'h2, 4'h3: avs_readdata <= {24'h000000, mem_rd};
				`NPIC_REG_VEN: avs_readdata <= {16'h0000, ven_ff};
				`NPIC_REG_EXT: avs_readdata <= {24'h000000, ext_cfg_ff};
				`NPIC_REG_CTRL: avs_readdata <= {24'h000000, ctrl_ff};
				`NPIC_REG_STAT: avs_readdata <= {6'h00, pend, last_idx_ff,
					3'h0, tli_lat_ff, trap_lat_ff, (state_ff != NPIC_S_IDLE),
					cc_prio};
				default: avs_readdata <= 32'h0000_0000;
			endcase
		end
	end

	// pin synchronisers
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ext_s1_ff <= 4'hf;
			ext_s2_ff <= 4'hf;
			tli_s1_ff <= 1'b0;
			tli_s2_ff <= 1'b0;
			tli_d_ff <= 1'b0;
			comb_d_ff <= 1'b1;
		end else begin
			ext_s1_ff <= ext_pin;
			ext_s2_ff <= ext_s1_ff;
			tli_s1_ff <= top_level_hw_interrupt;
			tli_s2_ff <= tli_s1_ff;
			tli_d_ff <= tli_s2_ff;
			comb_d_ff <= comb_lvl;
		end
	end

	// disabled pins read high so they never pull the group line
	assign comb_lvl = &(ext_s2_ff | ~ext_cfg_ff[7:4]);

	always_comb begin
		case (ext_cfg_ff[1:0])
			`NPIC_SENS_RISE: ext_edge = comb_lvl && !comb_d_ff;
			`NPIC_SENS_BOTH: ext_edge = comb_lvl != comb_d_ff;
			default: ext_edge = !comb_lvl && comb_d_ff;
		endcase
	end

	// low-level mode requests for as long as the group line is low
	assign ext_req = ext_lat_ff || (ext_cfg_ff[1:0] == `NPIC_SENS_FALL_LOW && !comb_lvl);
	assign tli_edge = TLI_RISING ? (tli_s2_ff && !tli_d_ff) : (!tli_s2_ff && tli_d_ff);
	assign per_req = periph_flag & periph_en;
	assign enter = (state_ff == NPIC_S_LOAD);

	// edge latch; a new edge in the entry cycle wins over the clear
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ext_lat_ff <= 1'b0;
		end else if (ext_edge) begin
			ext_lat_ff <= 1'b1;
		end else if (enter && !sel_nm_ff && sel_idx_ff == 4'(EXT_VEC)) begin
			ext_lat_ff <= 1'b0;
		end
	end

	// peripheral latches: set on a rising request, dropped by the clear pulse
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			per_d_ff <= 14'h0000;
			per_lat_ff <= 14'h0000;
		end else begin
			per_d_ff <= per_req;
			per_lat_ff <= (per_req & ~per_d_ff) | (per_lat_ff & ~periph_clr);
		end
	end

	// slot 0 is the top-level pin, the external group replaces its peripheral
	always_comb begin
		pend = per_lat_ff;
		pend[0] = 1'b0;
		pend[EXT_VEC] = ext_req;
	end

	// non-maskable latches, cleared only when their own entry happens
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			tli_lat_ff <= 1'b0;
			trap_lat_ff <= 1'b0;
		end else begin
			if (tli_edge) begin
				tli_lat_ff <= 1'b1;
			end else if (enter && sel_nm_ff && sel_idx_ff == `NPIC_IDX_TOP) begin
				tli_lat_ff <= 1'b0;
			end
			if (trap_exec) begin
				trap_lat_ff <= 1'b1;
			end else if (enter && sel_nm_ff && sel_idx_ff == `NPIC_IDX_TRAP) begin
				trap_lat_ff <= 1'b0;
			end
		end
	end

	assign nm_pend = tli_lat_ff || trap_lat_ff;

	// arbitration: scan from lowest hardware priority so lower indices win ties
	always_comb begin
		logic elig;
		elig = 1'b0;
		best_ok = 1'b0;
		best_idx = 4'h0;
		best_lvl = 2'd0;
		for (int i = NV - 1; i >= 1; i--) begin
			elig = pend[i] && ven_ff[i];
			elig = elig && (lvl(prio_flat[2*i+:2]) > lvl(cc_prio));
			elig = elig && (ctrl_ff[0] || cc_prio == `NPIC_LVL0);
			elig = elig && (!halt_exit_ff || HALT_CAP[i]);
			if (elig && (!best_ok || lvl(prio_flat[2*i+:2]) >= best_lvl)) begin
				best_ok = 1'b1;
				best_idx = 4'(i);
				best_lvl = lvl(prio_flat[2*i+:2]);
			end
		end
	end

	// service sequence: boundary, push, then vector load
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= NPIC_S_BOOT;
			ctx_push <= 1'b0;
			svc_strobe <= 1'b0;
			svc_index <= 4'h0;
			vec_addr <= 16'h0000;
			sel_nm_ff <= 1'b0;
			sel_idx_ff <= 4'h0;
			sel_prio_ff <= `NPIC_LVL3;
			last_idx_ff <= 4'h0;
		end else begin
			svc_strobe <= 1'b0;
			ctx_push <= 1'b0;
			case (state_ff)
				NPIC_S_BOOT: begin
					svc_strobe <= 1'b1;
					svc_index <= `NPIC_IDX_RESET;
					vec_addr <= `NPIC_VEC_RESET;
					last_idx_ff <= `NPIC_IDX_RESET;
					state_ff <= NPIC_S_IDLE;
				end
				NPIC_S_IDLE: begin
					if (instr_done && (nm_pend || best_ok)) begin
						ctx_push <= 1'b1;
						state_ff <= NPIC_S_PUSH;
						sel_nm_ff <= nm_pend;
						sel_prio_ff <= nm_pend ? `NPIC_LVL3 : prio_flat[2*best_idx+:2];
						if (tli_lat_ff) begin
							sel_idx_ff <= `NPIC_IDX_TOP;
						end else if (trap_lat_ff) begin
							sel_idx_ff <= `NPIC_IDX_TRAP;
						end else begin
							sel_idx_ff <= best_idx;
						end
					end
				end
				NPIC_S_PUSH: begin
					if (ctx_saved) begin
						state_ff <= NPIC_S_LOAD;
					end
				end
				NPIC_S_LOAD: begin
					svc_strobe <= 1'b1;
					svc_index <= sel_idx_ff;
					last_idx_ff <= sel_idx_ff;
					if (sel_idx_ff == `NPIC_IDX_TRAP) begin
						vec_addr <= `NPIC_VEC_TRAP;
					end else begin
						vec_addr <= vaddr(sel_idx_ff);
					end
					state_ff <= NPIC_S_IDLE;
				end
				default: state_ff <= NPIC_S_IDLE;
			endcase
		end
	end

	// current level: level 3 after reset, loaded on entry, reloaded by the core
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cc_prio <= `NPIC_LVL3;
		end else if (enter) begin
			cc_prio <= sel_prio_ff;
		end else if (cc_load) begin
			cc_prio <= cc_load_val;
		end
	end

	// halt exit restricts the first service to capable sources
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			halt_exit_ff <= 1'b0;
		end else if (halt_mode) begin
			halt_exit_ff <= 1'b1;
		end else if (enter || !(|(pend & ven_ff[13:0] & HALT_CAP))) begin
			halt_exit_ff <= 1'b0; // entry made or no capable source left, so do not block others
		end
	end

	// wake: wait takes any enabled source, halt only non-maskable and capable ones
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			wake <= 1'b0;
		end else begin
			wake <= (wait_mode && (nm_pend || |(pend & ven_ff[13:0])))
				|| (halt_mode && (nm_pend || |(pend & ven_ff[13:0] & HALT_CAP)));
		end
	end
endmodule // npic_ctrl

// >>> npic_ctrl_asserts.sv
// port checker for the nested priority interrupt controller
// assumes it is bound into npic_ctrl; one clock domain
`timescale 1ns/1ns
module npic_ctrl_asserts (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic avs_waitrequest,
	input wire logic instr_done,
	input wire logic cc_load,
	input wire npic_pkg::npic_prio_t cc_load_val,
	input wire logic ctx_saved,
	input wire logic halt_mode,
	input wire logic top_level_hw_interrupt,
	input wire npic_pkg::npic_prio_t cc_prio,
	input wire logic ctx_push,
	input wire logic svc_strobe,
	input wire logic [3:0] svc_index,
	input wire logic [15:0] vec_addr,
	input wire logic wake
);
	import npic_pkg::*;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	// entry only at an instruction boundary
	property p_entry; $rose(ctx_push) |-> $past(instr_done); endproperty
	a_entry: assert property (p_entry) else $error("push without boundary");
	// stacking request is one pulse, no strobe in the cycle after it
	property p_push; ctx_push |=> !ctx_push && !svc_strobe; endproperty
	a_push: assert property (p_push) else $error("push pulse wrong");
	// vector presented soon after stacking is done
	property p_load; ctx_saved |-> ##[1:3] svc_strobe; endproperty
	a_load: assert property (p_load) else $error("no strobe after stack");
	// return reloads the popped level
	property p_ret; cc_load && !svc_strobe |=> cc_prio == $past(cc_load_val) || svc_strobe;
	endproperty
	a_ret: assert property (p_ret) else $error("level not restored");
	// non-maskable entries end at level 3
	property p_nmi; svc_strobe && svc_index inside {4'h0, 4'he, 4'hf} |-> cc_prio == 2'b11;
	endproperty
	a_nmi: assert property (p_nmi) else $error("nmi level wrong");
	// maskable and top-level vectors step down by two from fffa
	property p_vec; svc_strobe && svc_index < 4'he |->
		vec_addr == 16'hfffa - {11'h000, svc_index, 1'b0}; endproperty
	a_vec: assert property (p_vec) else $error("vector address wrong");
	property p_rst; svc_strobe && svc_index == 4'hf |-> vec_addr == 16'hfffe; endproperty
	a_rst: assert property (p_rst) else $error("reset vector wrong");
	property p_trap; svc_strobe && svc_index == 4'he |-> vec_addr == 16'hfffc; endproperty
	a_trap: assert property (p_trap) else $error("trap vector wrong");
	// pin sync takes a few cycles, so allow a short window
	property p_wake; halt_mode && $fell(top_level_hw_interrupt) |-> ##[1:8] wake; endproperty
	a_wake: assert property (p_wake) else $error("no wake from halt");
	property p_bus; (avs_read || avs_write) && avs_waitrequest |-> ##[0:3] !avs_waitrequest;
	endproperty
	a_bus: assert property (p_bus) else $error("bus never answered");
	c_mask: cover property (svc_strobe && svc_index == 4'h7);
	c_trap: cover property (svc_strobe && svc_index == 4'he);
	c_wake: cover property (halt_mode && wake);
endmodule // npic_ctrl_asserts
bind npic_ctrl npic_ctrl_asserts npic_ctrl_asserts_inst (
	.core_clk(core_clk), .rst_n(rst_n), .avs_read(avs_read), .avs_write(avs_write),
	.avs_waitrequest(avs_waitrequest), .instr_done(instr_done), .cc_load(cc_load),
	.cc_load_val(cc_load_val), .ctx_saved(ctx_saved), .halt_mode(halt_mode),
	.top_level_hw_interrupt(top_level_hw_interrupt), .cc_prio(cc_prio),
	.ctx_push(ctx_push), .svc_strobe(svc_strobe), .svc_index(svc_index),
	.vec_addr(vec_addr), .wake(wake));

// >>> npic_core_model.sv
// behavioural core: boundaries, context stacking and returns
// assumes the controller pulses ctx_push once per entry
`timescale 1ns/1ns
module npic_core_model #(
	parameter int SAVE_DLY = 3
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic ctx_push,
	input wire npic_pkg::npic_prio_t cc_prio,
	input wire logic ret_req,
	input wire logic lvl_req,
	input wire npic_pkg::npic_prio_t lvl_val,
	output logic instr_done,
	output logic ctx_saved,
	output logic cc_load,
	output npic_pkg::npic_prio_t cc_load_val
);
	import npic_pkg::*;
	npic_prio_t stk[$];
	int cnt;
	// boundary every other cycle so entry has to wait for one
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			instr_done <= 1'b0;
			ctx_saved <= 1'b0;
			cc_load <= 1'b0;
			cc_load_val <= 2'b11;
			cnt <= 0;
		end else begin
			instr_done <= !instr_done;
			ctx_saved <= (cnt == 1);
			cc_load <= ret_req || lvl_req;
			if (ctx_push) begin
				cnt <= SAVE_DLY;
				stk.push_back(cc_prio);
			end else if (cnt > 0) begin
				cnt <= cnt - 1;
			end
			if (ret_req) begin
				cc_load_val <= stk.pop_back();
			end else if (lvl_req) begin
				cc_load_val <= lvl_val;
			end
		end
	end
endmodule // npic_core_model

// >>> npic_ctrl_tb_top.sv
// self-checking bench for the interrupt controller
// assumes the core model stands on the service link
`timescale 1ns/1ns
module npic_ctrl_tb_top;
	import npic_pkg::*;
	logic core_clk, rst_n, avs_read, avs_write, trap_exec, halt_mode, top_pin, wait_mode;
	logic ret_req, lvl_req, instr_done, ctx_saved, cc_load, ctx_push, svc_strobe, wake;
	logic avs_waitrequest;
	logic [3:0] avs_address, ext_pin, svc_index;
	logic [31:0] avs_writedata, avs_readdata, rd;
	logic [13:0] periph_flag, periph_en, periph_clr;
	logic [15:0] vec_addr;
	npic_prio_t cc_load_val, cc_prio, lvl_val;
	int num_errors, checked;
	npic_ctrl npic_ctrl_inst (.core_clk(core_clk), .rst_n(rst_n), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.instr_done(instr_done), .trap_exec(trap_exec), .cc_load(cc_load),
		.cc_load_val(cc_load_val), .ctx_saved(ctx_saved), .halt_mode(halt_mode),
		.wait_mode(wait_mode), .periph_flag(periph_flag), .periph_en(periph_en),
		.periph_clr(periph_clr), .ext_pin(ext_pin), .top_level_hw_interrupt(top_pin),
		.cc_prio(cc_prio), .ctx_push(ctx_push), .svc_strobe(svc_strobe),
		.svc_index(svc_index), .vec_addr(vec_addr), .wake(wake));
	npic_core_model npic_core_model_inst (.core_clk(core_clk), .rst_n(rst_n),
		.ctx_push(ctx_push), .cc_prio(cc_prio), .ret_req(ret_req), .lvl_req(lvl_req),
		.lvl_val(lvl_val), .instr_done(instr_done), .ctx_saved(ctx_saved),
		.cc_load(cc_load), .cc_load_val(cc_load_val));
	// free-running core clock, 50 ns
	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic miss(input string m);
		num_errors++;
		$display("MISMATCH %0t %s", $time, m);
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	// one avalon access; request held until waitrequest seen low
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge core_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		do begin
			@(posedge core_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 40);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (n >= 40) begin
			miss("bus timeout");
			tally_and_finish;
		end
	endtask
	task automatic chk_word(input logic [3:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		checked++;
		if (rd !== exp) miss("register word");
	endtask
	// waits for an entry strobe, then checks index, vector and level
	task automatic chk_svc(input logic [3:0] i, input logic [15:0] v, input npic_prio_t c);
		int n;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (svc_strobe !== 1'b1 && n < 200);
		checked++;
		if (svc_strobe !== 1'b1) begin
			miss("no service");
			tally_and_finish;
		end else if (svc_index !== i || vec_addr !== v || cc_prio !== c) begin
			miss("service entry");
		end
	endtask
	task automatic no_svc(input int n);
		checked++;
		repeat (n) begin
			@(posedge core_clk);
			if (svc_strobe === 1'b1) miss("unexpected service");
		end
	endtask
	// return (pop) or level load through the core model
	task automatic core(input logic r, input npic_prio_t v);
		ret_req <= r;
		lvl_req <= !r;
		lvl_val <= v;
		tick(1);
		ret_req <= 1'b0;
		lvl_req <= 1'b0;
		tick(4);
	endtask
	task automatic clr(input int i);
		periph_clr[i] <= 1'b1;
		periph_flag[i] <= 1'b0;
		tick(1);
		periph_clr[i] <= 1'b0;
	endtask
	initial begin
		{rst_n, avs_read, avs_write, trap_exec, halt_mode, wait_mode, ret_req, lvl_req} = '0;
		{avs_address, avs_writedata, periph_flag, periph_en, periph_clr} = '0;
		lvl_val = 2'b10;
		ext_pin = 4'hf;
		top_pin = 1'b1;
		num_errors = 0;
		checked = 0;
		tick(20);
		rst_n <= 1'b1;
		chk_svc(4'hf, 16'hfffe, 2'b11);
		chk_word(4'h7, 32'h0000_0f03);
		chk_word(4'h0, 32'hff);
		bus(1'b1, 4'h3, 32'h00);
		chk_word(4'h3, 32'hf0);
		chk_word(4'h8, 32'h0);
		bus(1'b1, 4'h0, 32'hcf);
		bus(1'b1, 4'h0, 32'h64);
		chk_word(4'h0, 32'h44);
		// v4 level 3, v5 and v6 level 1, v7 level 2
		bus(1'b1, 4'h1, 32'h17);
		bus(1'b1, 4'h4, 32'hf0);
		bus(1'b1, 4'h5, 32'h12);
		core(1'b0, 2'b10);
		periph_flag <= 14'h00e0;
		no_svc(12);
		periph_en <= 14'h00e0;
		chk_svc(4'h7, 16'hffec, 2'b00);
		no_svc(20);
		clr(7);
		core(1'b1, 2'b10);
		chk_svc(4'h5, 16'hfff0, 2'b01);
		clr(5);
		core(1'b1, 2'b10);
		chk_svc(4'h6, 16'hffee, 2'b01);
		clr(6);
		core(1'b1, 2'b10);
		core(1'b0, 2'b11);
		periph_flag[5] <= 1'b1;
		wait_mode <= 1'b1;
		tick(5);
		checked++;
		if (wake !== 1'b1) miss("no wake from wait");
		wait_mode <= 1'b0;
		halt_mode <= 1'b1;
		tick(3);
		checked++;
		if (wake !== 1'b0) miss("halt woken by incapable source");
		halt_mode <= 1'b0;
		clr(5);
		core(1'b0, 2'b10);
		no_svc(20);
		ext_pin[0] <= 1'b0;
		chk_svc(4'h4, 16'hfff2, 2'b11);
		core(1'b1, 2'b10);
		no_svc(20);
		ext_pin[0] <= 1'b1;
		halt_mode <= 1'b1;
		top_pin <= 1'b0;
		tick(6);
		checked++;
		if (wake !== 1'b1) miss("no wake");
		halt_mode <= 1'b0;
		chk_svc(4'h0, 16'hfffa, 2'b11);
		top_pin <= 1'b1;
		core(1'b1, 2'b10);
		tick(5);
		trap_exec <= 1'b1;
		tick(1);
		trap_exec <= 1'b0;
		chk_svc(4'he, 16'hfffc, 2'b11);
		top_pin <= 1'b0;
		chk_svc(4'h0, 16'hfffa, 2'b11);
		core(1'b1, 2'b10);
		core(1'b1, 2'b10);
		top_pin <= 1'b1;
		tally_and_finish;
	end
endmodule // npic_ctrl_tb_top
